// ===== scan_cycle_timing.v
// Scan cycle timing control with pass and fail result outputs
//
// Contract
// RL1 - Pass output on read or verify success
// RL2 - Fail output on read or verify failure
// RL3 - Per-output polarity selects active high or low
// RL4 - Output time unlimited or 100 to 2550 ms
// RL5 - New request forces result outputs inactive
// RL6 - Reading timeout aborts exposure, processing, decoding
// RL7 - Reading timeout unlimited or 100 to 25500 ms
// RL8 - Decode timeout unlimited or 100 to 25500 ms
// RL9 - Host keeps decode timeout below reading timeout
// RL10 - Trigger filter time 1 to 100 ms
// RL11 - Exposure time 0.09 to 10.00 ms
// RL12 - Image processing at most 27.80 ms
// RL13 - Lighting limit set by mode and frame rate
// RL14 - Unlimited output holds until next request
`timescale 1ns/1ps
`include "scan_cycle_consts.vh"
module scan_cycle_timing #(
  parameter MS_CYC  = `MS_CYCLES,    // Clock cycles per millisecond
  parameter US10_CYC = `EXP_STEP_CYC // Clock cycles per 10 us step
) (
  input  wire        ref_clk_i,      // 125 MHz clock
  input  wire        rstn_i,         // Synchronous reset, active low
  input  wire        trig_i,         // Raw reading trigger, active high
  input  wire [6:0]  filt_ms_i,      // Trigger filter time in ms
  input  wire [9:0]  exp_time_i,     // Exposure in 10 us steps
  input  wire        boost_i,        // Boost lighting mode
  input  wire [1:0]  rate_sel_i,     // 0 hq 36fps, 1 hq 40fps, else other
  input  wire [11:0] read_tmo_i,     // Reading timeout, 10 ms steps, 0 unlimited
  input  wire [11:0] dec_tmo_i,      // Decode timeout, 10 ms steps, 0 unlimited
  input  wire [7:0]  out_time_i,     // Output time, 10 ms steps, 0 unlimited
  input  wire        pass_pol_i,     // Pass output polarity, 1 positive
  input  wire        fail_pol_i,     // Fail output polarity, 1 positive
  input  wire        proc_done_i,    // Image processing finished
  input  wire        dec_done_i,     // Decoder finished
  input  wire        dec_ok_i,       // Decode or verification result good
  output wire        light_o,        // Emitter lighting enable
  output wire        expose_o,       // Sensor exposure enable
  output wire        process_o,      // Image processing enable
  output wire        decode_o,       // Decoder enable
  output wire        abort_o,        // Cycle aborted by reading timeout
  output wire        pass_o,         // Pass result output
  output wire        fail_o          // Fail result output
);

  // Clamp settings into their documented ranges
  wire [6:0]  filt_ms = (filt_ms_i < `FILT_MIN_MS) ? `FILT_MIN_MS :
                        (filt_ms_i > `FILT_MAX_MS) ? `FILT_MAX_MS : filt_ms_i; // RL10
  wire [9:0]  exp_st  = (exp_time_i < `EXP_MIN) ? `EXP_MIN :
                        (exp_time_i > `EXP_MAX) ? `EXP_MAX : exp_time_i; // RL11
  wire [11:0] rd_tmo  = (read_tmo_i == 12'h000) ? 12'h000 :
                        (read_tmo_i < `TMO_MIN) ? `TMO_MIN :
                        (read_tmo_i > `TMO_MAX) ? `TMO_MAX : read_tmo_i; // RL7
  wire [11:0] dc_tmo  = (dec_tmo_i == 12'h000) ? 12'h000 :
                        (dec_tmo_i < `TMO_MIN) ? `TMO_MIN :
                        (dec_tmo_i > `TMO_MAX) ? `TMO_MAX : dec_tmo_i; // RL8
  wire [7:0]  o_time  = (out_time_i == 8'h00) ? 8'h00 :
                        (out_time_i < `OUT_TIME_MIN) ? `OUT_TIME_MIN : out_time_i; // RL4

  // Lighting limit by mode and frame rate
  wire [9:0] light_lim = !boost_i ? `LIGHT_NORMAL :
                         (rate_sel_i == 2'b00) ? `LIGHT_BOOST_36 :
                         (rate_sel_i == 2'b01) ? `LIGHT_BOOST_40 : `LIGHT_BOOST_OTH; // RL13

  // Shared prescalers: 1 ms tick and 10 us tick
  reg [16:0] ms_cnt_q;
  reg [10:0] us_cnt_q;
  wire ms_tick = (ms_cnt_q == MS_CYC - 1);
  wire us_tick = (us_cnt_q == US10_CYC - 1);
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ms_cnt_q <= 17'h0_0000;
      us_cnt_q <= 11'h000;
    end else begin
      ms_cnt_q <= ms_tick ? 17'h0_0000 : ms_cnt_q + 17'h0_0001;
      us_cnt_q <= us_tick ? 11'h000 : us_cnt_q + 11'h001;
    end
  end

  // Trigger filter: level must hold a full filter time before it is accepted
  reg [6:0] filt_cnt_q;
  reg       trig_raw_q;
  reg       trig_q;
  reg       trig_prev_q;
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      filt_cnt_q  <= 7'h00;
      trig_raw_q  <= 1'b0;
      trig_q      <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_raw_q  <= trig_i;
      trig_prev_q <= trig_q;
      if (trig_raw_q == trig_q) begin
        filt_cnt_q <= 7'h00;
      end else if (ms_tick) begin
        // First tick only starts the count, so a pulse shorter than the filter never lands
        if (filt_cnt_q >= filt_ms) begin // RL10
          trig_q     <= trig_raw_q;
          filt_cnt_q <= 7'h00;
        end else begin
          filt_cnt_q <= filt_cnt_q + 7'h01;
        end
      end
    end
  end
  wire req = trig_q & ~trig_prev_q; // Filtered rising edge starts a cycle

  // Read cycle phases
  reg [2:0]  ph_q;
  reg [11:0] ph_cnt_q;   // 10 us steps within expose and process
  reg [11:0] rd_cnt_q;   // 10 ms steps since request
  reg [11:0] dc_cnt_q;   // 10 ms steps in decode
  reg [3:0]  step_q;     // ms within a 10 ms step
  reg        abort_q;
  reg        res_ok_q;
  reg        res_vld_q;
  wire step_tick = ms_tick && (step_q == 4'h9);
  wire rd_expired = (rd_tmo != 12'h000) && (rd_cnt_q >= rd_tmo);
  wire dc_expired = (dc_tmo != 12'h000) && (dc_cnt_q >= dc_tmo);

  // Sequencer; reading timeout overrides every phase
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ph_q      <= `PH_IDLE;
      ph_cnt_q  <= 12'h000;
      rd_cnt_q  <= 12'h000;
      dc_cnt_q  <= 12'h000;
      step_q    <= 4'h0;
      abort_q   <= 1'b0;
      res_ok_q  <= 1'b0;
      res_vld_q <= 1'b0;
    end else begin
      res_vld_q <= 1'b0;
      if (ms_tick) begin
        step_q <= (step_q == 4'h9) ? 4'h0 : step_q + 4'h1;
      end
      if (ph_q != `PH_IDLE && step_tick) begin
        rd_cnt_q <= rd_cnt_q + 12'h001;
      end
      if (req) begin
        ph_q     <= `PH_EXPOSE;
        ph_cnt_q <= 12'h000;
        rd_cnt_q <= 12'h000;
        dc_cnt_q <= 12'h000;
        step_q   <= 4'h0;
        abort_q  <= 1'b0;
      end else if (ph_q != `PH_IDLE && rd_expired) begin
        ph_q      <= `PH_IDLE; // RL6
        abort_q   <= 1'b1;     // RL6
        res_ok_q  <= 1'b0;
        res_vld_q <= 1'b1;     // RL2
      end else begin
        case (ph_q)
          `PH_IDLE: begin
            ph_cnt_q <= 12'h000;
          end
          `PH_EXPOSE: begin
            if (us_tick) begin
              if (ph_cnt_q + 12'h001 >= {2'b00, exp_st}) begin // RL11
                ph_q     <= `PH_PROCESS;
                ph_cnt_q <= 12'h000;
              end else begin
                ph_cnt_q <= ph_cnt_q + 12'h001;
              end
            end
          end
          `PH_PROCESS: begin
            // Processing is cut off at its limit so a stalled stage cannot overrun
            if (proc_done_i || (us_tick && ph_cnt_q + 12'h001 >= `PROC_MAX)) begin // RL12
              ph_q     <= `PH_DECODE;
              ph_cnt_q <= 12'h000;
            end else if (us_tick) begin
              ph_cnt_q <= ph_cnt_q + 12'h001;
            end
          end
          `PH_DECODE: begin
            if (step_tick) begin
              dc_cnt_q <= dc_cnt_q + 12'h001;
            end
            if (dec_done_i) begin
              ph_q      <= `PH_IDLE;
              res_ok_q  <= dec_ok_i;  // RL1
              res_vld_q <= 1'b1;
            end else if (dc_expired) begin
              ph_q      <= `PH_IDLE;  // RL8
              res_ok_q  <= 1'b0;      // RL2
              res_vld_q <= 1'b1;
            end
          end
          default: begin
            ph_q <= `PH_IDLE;
          end
        endcase
      end
    end
  end

  // Lighting follows exposure but is cut at the lighting limit
  wire light_on = (ph_q == `PH_EXPOSE) && (ph_cnt_q < {2'b00, light_lim}); // RL13

  // Result outputs and their hold timer
  reg        pass_act_q;
  reg        fail_act_q;
  reg [7:0]  out_cnt_q;
  reg [3:0]  out_step_q;
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pass_act_q <= 1'b0;
      fail_act_q <= 1'b0;
      out_cnt_q  <= 8'h00;
      out_step_q <= 4'h0;
    end else if (req) begin
      pass_act_q <= 1'b0; // RL5
      fail_act_q <= 1'b0; // RL5
    end else if (res_vld_q) begin
      pass_act_q <= res_ok_q;  // RL1
      fail_act_q <= ~res_ok_q; // RL2
      out_cnt_q  <= 8'h00;
      out_step_q <= 4'h0;
    end else if ((pass_act_q || fail_act_q) && o_time != 8'h00 && ms_tick) begin
      // Zero setting skips this, so the output holds until the next request
      out_step_q <= (out_step_q == 4'h9) ? 4'h0 : out_step_q + 4'h1; // RL14
      if (out_step_q == 4'h9) begin
        if (out_cnt_q + 8'h01 >= o_time) begin // RL4
          pass_act_q <= 1'b0;
          fail_act_q <= 1'b0;
        end
        out_cnt_q <= out_cnt_q + 8'h01;
      end
    end
  end

  // Output flops, polarity applied before the register
  reg pass_q;
  reg fail_q;
  reg light_q;
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pass_q  <= 1'b0;
      fail_q  <= 1'b0;
      light_q <= 1'b0;
    end else begin
      pass_q  <= pass_act_q ~^ pass_pol_i; // RL3
      fail_q  <= fail_act_q ~^ fail_pol_i; // RL3
      light_q <= light_on;
    end
  end

  assign pass_o    = pass_q;
  assign fail_o    = fail_q;
  assign light_o   = light_q;
  assign expose_o  = (ph_q == `PH_EXPOSE);
  assign process_o = (ph_q == `PH_PROCESS);
  assign decode_o  = (ph_q == `PH_DECODE);
  assign abort_o   = abort_q;

endmodule

// ===== scan_cycle_consts.vh
// Constants for the scan cycle timing and result output block
`ifndef SCAN_CYCLE_CONSTS_VH
`define SCAN_CYCLE_CONSTS_VH
`define CLK_HZ            125000000
`define MS_CYCLES         125000
// Setting units: output and timeout settings are in 10 ms steps, 0 = unlimited
`define STEP_MS           10
`define OUT_TIME_MIN      8'h0A
`define TMO_MIN           12'h00A
`define TMO_MAX           12'h9F6
`define FILT_MIN_MS       7'h01
`define FILT_MAX_MS       7'h64
// Exposure in 10 us steps: 0.09 ms to 10.00 ms
`define EXP_STEP_CYC      1250
`define EXP_MIN           10'h009
`define EXP_MAX           10'h3E8
// Processing limit 27.80 ms, in 10 us steps
`define PROC_MAX          12'h0AD_C
// Lighting limits in 10 us steps
`define LIGHT_NORMAL      10'h1F4
`define LIGHT_BOOST_36    10'h08C
`define LIGHT_BOOST_40    10'h064
`define LIGHT_BOOST_OTH   10'h050
// Phase encodings
`define PH_IDLE           3'h0
`define PH_EXPOSE         3'h1
`define PH_PROCESS        3'h2
`define PH_DECODE         3'h3
`define PH_DONE           3'h4
`endif

// ===== scan_cycle_checker.sv
// Assertion checker for the scan cycle timing block ports
`timescale 1ns/1ps
`include "scan_cycle_consts.vh"
module scan_cycle_checker #(
  parameter MS_CYC   = 10, // Cycles per ms
  parameter US10_CYC = 2   // Cycles per 10 us
) (
  input wire       ref_clk_i,  // Clock
  input wire       rstn_i,     // Reset, active low
  input wire       boost_i,    // Boost lighting
  input wire [1:0] rate_sel_i, // Frame rate select
  input wire [7:0] out_time_i, // Output time
  input wire       pass_pol_i, // Pass polarity
  input wire       fail_pol_i, // Fail polarity
  input wire       dec_done_i, // Decode done
  input wire       dec_ok_i,   // Decode good
  input wire       light_o,    // Lighting
  input wire       expose_o,   // Exposure
  input wire       process_o,  // Processing
  input wire       decode_o,   // Decoding
  input wire       abort_o,    // Aborted
  input wire       pass_o,     // Pass result
  input wire       fail_o      // Fail result
);
  wire        pass_act = pass_o == pass_pol_i;
  wire        fail_act = fail_o == fail_pol_i;
  wire [9:0]  lim      = !boost_i ? `LIGHT_NORMAL : rate_sel_i == 2'h0 ? `LIGHT_BOOST_36 :
                         rate_sel_i == 2'h1 ? `LIGHT_BOOST_40 : `LIGHT_BOOST_OTH;
  wire [7:0]  out_t    = out_time_i < `OUT_TIME_MIN ? `OUT_TIME_MIN : out_time_i;
  reg  [15:0] light_q;
  reg  [15:0] proc_q;
  reg  [19:0] res_q;
  // Run lengths; a polarity change also restarts the result run, so keep it stable
  always @(posedge ref_clk_i) begin
    light_q <= light_o ? light_q + 16'h0001 : 16'h0000;
    proc_q  <= process_o ? proc_q + 16'h0001 : 16'h0000;
    res_q   <= (pass_act || fail_act) ? res_q + 20'h0_0001 : 20'h0_0000;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_CLEAR:
    assert property ($rose(expose_o) |-> ##1 !pass_act && !fail_act) else $error("result not cleared");
  AST_PASS:
    assert property (decode_o && dec_done_i && dec_ok_i |-> ##3 pass_act) else $error("no pass");
  AST_FAIL:
    assert property (decode_o && dec_done_i && !dec_ok_i |-> ##3 fail_act) else $error("no fail");
  AST_ABORT:
    assert property ($rose(abort_o) |-> !expose_o && !process_o && !decode_o) else $error("abort");
  AST_PHASE:
    assert property ($onehot0({expose_o, process_o, decode_o})) else $error("phases overlap");
  AST_PROC:
    assert property (process_o |-> proc_q < `PROC_MAX * US10_CYC + 2) else $error("long process");
  AST_LIGHT:
    assert property (light_o |-> light_q < lim * US10_CYC + 2) else $error("lighting too long");
  AST_HOLD:
    assert property (out_time_i != 8'h00 |-> res_q <= out_t * 10 * MS_CYC + 2 * MS_CYC)
      else $error("result held too long");
endmodule

// ===== scan_pipe_model.sv
// Image pipeline stand-in answering the processing and decode phases
`timescale 1ns/1ps
module scan_pipe_model (
  input  wire clk_i,              // Bench clock
  input  wire process_i,          // Processing phase
  input  wire decode_i,           // Decode phase
  input  wire ok_i,               // Outcome to report
  input  wire mute_i,             // Decoder stays silent
  input  wire stall_i,            // Processing stage never answers
  output reg  proc_done_o = 1'b0, // Processing finished
  output reg  dec_done_o  = 1'b0, // Decoding finished
  output reg  dec_ok_o    = 1'b0  // Outcome, meaningful with done only
);
  reg [7:0] pc_q = 8'h00;
  reg [7:0] dc_q = 8'h00;
  // Fixed latencies; outcome toggles when unqualified so a stale value never helps
  always @(negedge clk_i) begin
    pc_q        <= process_i ? pc_q + 8'h01 : 8'h00;
    dc_q        <= decode_i ? dc_q + 8'h01 : 8'h00;
    proc_done_o <= process_i && !stall_i && pc_q == 8'h14;
    dec_done_o  <= decode_i && !mute_i && dc_q == 8'h0C;
    dec_ok_o    <= (decode_i && !mute_i && dc_q == 8'h0C) ? ok_i : ~dec_ok_o;
  end
endmodule

// ===== scan_cycle_timing_bench.sv
// Self-checking bench for the scan cycle timing block
`timescale 1ns/1ps
module scan_cycle_timing_bench;
  reg ref_clk_i = 0, rstn_i = 0, trig_i = 0, boost_i = 0, pass_pol_i = 1, fail_pol_i = 1;
  reg ok = 1, mute = 0, stall = 0;
  reg [1:0] rsel = 2'h0;
  reg [9:0] expt = 10'h009;
  reg [11:0] rtmo = 12'h000, dtmo = 12'h000;
  reg [7:0] otime = 8'h0A;
  wire light_o, expose_o, process_o, decode_o, abort_o, pass_o, fail_o, pd, dd, dk;
  integer err_total = 0, samples_checked = 0, n, m;
  scan_cycle_timing #(.MS_CYC(10), .US10_CYC(2)) u_scan_cycle_timing (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .trig_i(trig_i), .filt_ms_i(7'h01), .exp_time_i(expt), .boost_i(boost_i),
    .rate_sel_i(rsel), .read_tmo_i(rtmo), .dec_tmo_i(dtmo), .out_time_i(otime),
    .pass_pol_i(pass_pol_i), .fail_pol_i(fail_pol_i), .proc_done_i(pd), .dec_done_i(dd),
    .dec_ok_i(dk), .light_o(light_o), .expose_o(expose_o), .process_o(process_o),
    .decode_o(decode_o), .abort_o(abort_o), .pass_o(pass_o), .fail_o(fail_o));
  scan_pipe_model u_scan_pipe_model (.clk_i(ref_clk_i), .process_i(process_o), .decode_i(decode_o),
    .ok_i(ok), .mute_i(mute), .stall_i(stall), .proc_done_o(pd), .dec_done_o(dd),
    .dec_ok_o(dk));
  task chk(input [8*8:1] what, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task results;
    begin
      if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Hold trigger until taken, then let the forced clear land
  task req;
    begin
      @(negedge ref_clk_i) trig_i = 1;
      for (n = 0; expose_o !== 1'b1 && n < 60; n = n + 1) @(negedge ref_clk_i);
      chk("taken", expose_o, 1);
      trig_i = 0;
      repeat (2) @(negedge ref_clk_i);
    end
  endtask
  task wres(input integer lim);
    for (n = 0; pass_o !== pass_pol_i && fail_o !== fail_pol_i && n < lim; n = n + 1)
      @(negedge ref_clk_i);
  endtask
  // Short glitch ignored, then good read held for the programmed time
  task t_pass;
    begin
      @(negedge ref_clk_i) trig_i = 1;
      repeat (4) @(negedge ref_clk_i);
      trig_i = 0;
      repeat (40) @(negedge ref_clk_i);
      chk("glitch", expose_o, 0);
      req;
      wres(2000);
      chk("pass", pass_o, 1);
      chk("nofail", fail_o, 0);
      for (m = 0; pass_o === 1'b1 && m < 3000; m = m + 1) @(negedge ref_clk_i);
      chk("hold", m >= 990 && m <= 1010, 1);
    end
  endtask
  // Negative polarity failure, unlimited hold, cleared by a new request
  task t_fail;
    begin
      otime = 8'h00;
      ok = 0;
      pass_pol_i = 0;
      fail_pol_i = 0;
      req;
      wres(2000);
      chk("fail", fail_o, 0);
      chk("passoff", pass_o, 1);
      repeat (3000) @(negedge ref_clk_i);
      chk("forever", fail_o, 0);
      req;
      chk("cleared", fail_o, 1);
      wres(2000);
    end
  endtask
  // Silent decoder; reading timeout aborts the cycle
  task t_rd_tmo;
    begin
      mute = 1;
      rtmo = 12'h00A;
      req;
      otime = 8'h0A;
      for (m = 0; abort_o !== 1'b1 && m < 1500; m = m + 1) @(negedge ref_clk_i);
      chk("abort", abort_o, 1);
      chk("span", m >= 970 && m <= 1030, 1);
      chk("nodec", decode_o, 0);
      wres(20);
      chk("tmofail", fail_o, fail_pol_i);
    end
  endtask
  // Decode timeout ends the cycle before the reading timeout
  task t_dec_tmo;
    begin
      rtmo = 12'h01E;
      dtmo = 12'h00A;
      req;
      wres(3500);
      chk("decfail", fail_o, fail_pol_i);
      chk("noabort", abort_o, 0);
    end
  endtask
  // Stalled processing stage is cut off at its limit, then decode runs
  task t_proc;
    begin
      mute = 0;
      ok = 1;
      stall = 1;
      rtmo = 12'h000;
      dtmo = 12'h000;
      req;
      for (m = 0; process_o !== 1'b1 && m < 100; m = m + 1) @(negedge ref_clk_i);
      for (m = 0; process_o === 1'b1 && m < 7000; m = m + 1) @(negedge ref_clk_i);
      chk("proclim", m >= 5550 && m <= 5562, 1);
      chk("procdec", decode_o, 1);
      stall = 0;
      wres(200);
      chk("procok", pass_o, pass_pol_i);
    end
  endtask
  // Lighting run within a 2 ms exposure, per mode and frame rate
  task t_light(input bst, input [1:0] rate, input integer lo, input integer hi);
    begin
      mute = 0;
      ok = 1;
      boost_i = bst;
      rsel = rate;
      expt = 10'h0C8;
      req;
      n = 0;
      for (m = 0; expose_o === 1'b1 && m < 1000; m = m + 1) begin
        n = n + light_o;
        @(negedge ref_clk_i);
      end
      chk("expose", m >= 390 && m <= 400, 1);
      chk("light", n >= lo && n <= hi, 1);
      wres(2000);
      chk("boostok", pass_o, pass_pol_i);
    end
  endtask
  initial forever #4 ref_clk_i = ~ref_clk_i;
  // Watchdog sized well past the longest expected run
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    err_total = err_total + 1;
    results;
  end
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rstn_i = 1;
    repeat (4) @(negedge ref_clk_i);
    t_pass;
    t_fail;
    t_rd_tmo;
    t_dec_tmo;
    t_proc;
    t_light(1'b0, 2'h0, 390, 400);
    t_light(1'b1, 2'h0, 268, 282);
    t_light(1'b1, 2'h1, 190, 202);
    t_light(1'b1, 2'h2, 150, 162);
    results;
  end
endmodule
bind scan_cycle_timing scan_cycle_checker #(.MS_CYC(MS_CYC), .US10_CYC(US10_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .boost_i(boost_i), .rate_sel_i(rate_sel_i),
  .out_time_i(out_time_i), .pass_pol_i(pass_pol_i), .fail_pol_i(fail_pol_i),
  .dec_done_i(dec_done_i), .dec_ok_i(dec_ok_i), .light_o(light_o), .expose_o(expose_o),
  .process_o(process_o), .decode_o(decode_o), .abort_o(abort_o), .pass_o(pass_o),
  .fail_o(fail_o));
